/* serial_port_sleep_control_test.sv */
// Register and sleep-mode tests of the serial port against the host model
`timescale 1ns/1ps
`include "spu_defs.svh"

module serial_port_sleep_control_test;
   logic                   clk = 1'b0;
   logic                   sys_rst = 1'b1;
   logic [`SPU_ADDR_W-1:0] addr = '0;
   logic [7:0]             wdata = 8'h00;
   logic                   wr = 1'b0;
   logic                   rd = 1'b0;
   logic [7:0]             rdata;
   logic                   cpu_sleep = 1'b0;
   logic                   data_in;
   logic                   data_out;
   logic                   data_oe_n;
   logic                   clk_pin_in;
   logic                   clk_pin_out;
   logic                   clk_pin_oe_n;
   logic                   receive_flag;
   logic                   transmit_flag;
   int                     errors = 0;
   int                     n_compared = 0;
   int                     cycles = 0;
   int                     k;
   logic [8:0]             w;
   logic [7:0]             r;

   spu_serial_port #(.BAUD_DIV(16'h0001)) dut (
      .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .cpu_sleep(cpu_sleep), .data_in(data_in), .data_out(data_out),
      .data_oe_n(data_oe_n), .clk_pin_in(clk_pin_in), .clk_pin_out(clk_pin_out),
      .clk_pin_oe_n(clk_pin_oe_n), .receive_flag(receive_flag),
      .transmit_flag(transmit_flag));

   spu_host_model host (
      .clk(clk), .data_out(data_out), .data_oe_n(data_oe_n),
      .clk_pin_out(clk_pin_out), .clk_pin_oe_n(clk_pin_oe_n),
      .data_in(data_in), .clk_pin_in(clk_pin_in));

   initial begin
      forever #2.5 clk = ~clk;
   end

   task automatic test_done();
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         test_done();
      end
   end

   task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [`SPU_ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [`SPU_ADDR_W-1:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask

   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      rd_reg(`SPU_RXC_ADDR, r); chk("rx ctrl reset", 9'h000, r);
      rd_reg(`SPU_TXC_ADDR, r); chk("tx ctrl reset", 9'h002, r);
      rd_reg(`SPU_BDC_ADDR, r); chk("div ctrl reset", 9'h040, r);
      wr_reg(`SPU_BDC_ADDR, 8'hff);
      rd_reg(`SPU_BDC_ADDR, r); chk("div ctrl mask", 9'h05b, r);
      wr_reg(`SPU_BDC_ADDR, 8'h00);
      rd_reg(12'h713, r); chk("unmapped", 9'h000, r);
      // Client reception while asleep
      wr_reg(`SPU_TXC_ADDR, 8'h10);
      wr_reg(`SPU_RXC_ADDR, 8'h90);
      cpu_sleep <= 1'b1;
      host.send_word(9'h0a5, 8);
      chk("rx flag asleep", 9'h001, receive_flag);
      cpu_sleep <= 1'b0;
      rd_reg(`SPU_RXDATA_ADDR, r); chk("rx data", 9'h0a5, r);
      chk("rx flag drained", 9'h000, receive_flag);
      // Third word overruns the two-deep buffer
      host.send_word(9'h011, 8);
      host.send_word(9'h022, 8);
      host.send_word(9'h033, 8);
      rd_reg(`SPU_RXC_ADDR, r); chk("overrun set", 9'h092, r);
      rd_reg(`SPU_RXDATA_ADDR, r); chk("rx head", 9'h011, r);
      rd_reg(`SPU_RXDATA_ADDR, r); chk("rx second", 9'h022, r);
      wr_reg(`SPU_RXC_ADDR, 8'h80);
      rd_reg(`SPU_RXC_ADDR, r); chk("overrun clear", 9'h080, r);
      // Nine-bit word
      wr_reg(`SPU_RXC_ADDR, 8'hd0);
      host.send_word(9'h1c3, 9);
      rd_reg(`SPU_RXC_ADDR, r); chk("rx ninth", 9'h0d1, r);
      rd_reg(`SPU_RXDATA_ADDR, r); chk("rx9 data", 9'h0c3, r);
      // Rising-edge sampling
      wr_reg(`SPU_BDC_ADDR, 8'h10);
      wr_reg(`SPU_RXC_ADDR, 8'h90);
      host.send_word(9'h096, 8);
      rd_reg(`SPU_RXDATA_ADDR, r); chk("rx rising", 9'h096, r);
      wr_reg(`SPU_BDC_ADDR, 8'h00);
      // Client transmission while asleep
      wr_reg(`SPU_RXC_ADDR, 8'h80);
      wr_reg(`SPU_TXC_ADDR, 8'h30);
      repeat (3) @(posedge clk);
      chk("tx flag empty", 9'h001, transmit_flag);
      wr_reg(`SPU_TXDATA_ADDR, 8'h3c);
      wr_reg(`SPU_TXDATA_ADDR, 8'h5a);
      repeat (4) @(posedge clk);
      chk("tx flag full", 9'h000, transmit_flag);
      chk("data drive", 9'h000, data_oe_n);
      chk("clock released", 9'h001, clk_pin_oe_n);
      rd_reg(`SPU_TXC_ADDR, r); chk("shift busy", 9'h030, r);
      cpu_sleep <= 1'b1;
      host.recv_word(w, 8); chk("tx word 1", 9'h03c, w);
      chk("tx flag reload", 9'h001, transmit_flag);
      host.recv_word(w, 8); chk("tx word 2", 9'h05a, w);
      cpu_sleep <= 1'b0;
      repeat (8) @(posedge clk);
      rd_reg(`SPU_TXC_ADDR, r); chk("shift empty", 9'h032, r);
      // Asynchronous transmit holds still while asleep
      wr_reg(`SPU_TXC_ADDR, 8'h20);
      cpu_sleep <= 1'b1;
      wr_reg(`SPU_TXDATA_ADDR, 8'h55);
      k = 0;
      repeat (150) @(posedge clk) if (clk_pin_out !== 1'b1) k++;
      chk("async asleep", 9'h000, k[8:0]);
      cpu_sleep <= 1'b0;
      k = 0;
      while (k < 200 && clk_pin_out !== 1'b0) @(posedge clk) k++;
      chk("async start", 9'h001, (k < 200) ? 9'h001 : 9'h000);
      for (int i = 0; i < 9; i++) begin
         repeat ((i == 0) ? 96 : 64) @(posedge clk);
         w = {clk_pin_out, w[8:1]};
      end
      chk("async frame", 9'h155, w);
      repeat (64) @(posedge clk);
      test_done();
   end
endmodule

/* spu_defs.svh */
// Register map, field positions, reset values and counts of the serial port
`ifndef SPU_DEFS_SVH
`define SPU_DEFS_SVH

`define SPU_ADDR_W        12
`define SPU_RXDATA_ADDR   12'h70c
`define SPU_TXDATA_ADDR   12'h70d
`define SPU_RXC_ADDR      12'h710
`define SPU_TXC_ADDR      12'h711
`define SPU_BDC_ADDR      12'h712

`define SPU_RXC_PORT_EN   7
`define SPU_RXC_NINE      6
`define SPU_RXC_ONCE      5
`define SPU_RXC_CONT      4
`define SPU_RXC_ADDR_DET  3

`define SPU_TXC_CLK_SRC   7
`define SPU_TXC_NINE      6
`define SPU_TXC_TX_EN     5
`define SPU_TXC_SYNC      4
`define SPU_TXC_BREAK     3
`define SPU_TXC_FAST      2
`define SPU_TXC_EMPTY     1
`define SPU_TXC_NINTH     0

`define SPU_BDC_POLARITY  4
`define SPU_BDC_WIDE      3

`define SPU_RXC_RESET     8'h00
`define SPU_TXC_RESET     8'h02
`define SPU_BDC_RESET     8'h40
`define SPU_RXC_WMASK     8'hf8
`define SPU_TXC_WMASK     8'hfd
`define SPU_BDC_WMASK     8'h1b

`define SPU_SHIFT_DIV4    3'h2
`define SPU_SHIFT_DIV16   3'h4
`define SPU_SHIFT_DIV64   3'h6

`define SPU_BITS_8        4'h8
`define SPU_BITS_9        4'h9
`define SPU_FRAME_EXTRA   4'h2
`define SPU_BREAK_LEN     4'he
`define SPU_FIFO_FULL     2'h2

`endif

/* spu_host_model.sv */
// External synchronous host that drives the link clock and data pins
`timescale 1ns/1ps

module spu_host_model (
   input  wire logic clk,
   input  wire logic data_out,
   input  wire logic data_oe_n,
   input  wire logic clk_pin_out,
   input  wire logic clk_pin_oe_n,
   output logic      data_in,
   output logic      clk_pin_in
);
   localparam int HALF = 8;
   logic host_ck = 1'b0;
   logic host_d  = 1'b1;
   logic sending = 1'b0;

   // Wire levels from every driver; released data line keeps changing
   assign data_in    = data_oe_n ? host_d : data_out;
   assign clk_pin_in = clk_pin_oe_n ? host_ck : clk_pin_out;

   always @(posedge clk) begin
      if (!sending) host_d <= ~host_d;
   end

   // Host clocks a word in, LSB first; clock idles low between words
   task automatic send_word(input logic [8:0] w, input int n);
      sending <= 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge clk) host_d <= w[i];
         repeat (HALF) @(posedge clk);
         host_ck <= 1'b1;
         repeat (HALF) @(posedge clk);
         host_ck <= 1'b0;
         repeat (HALF) @(posedge clk);
      end
      sending <= 1'b0;
   endtask

   // Host clocks a word out of the device, sampling before the falling edge
   task automatic recv_word(output logic [8:0] w, input int n);
      w = 9'h000;
      for (int i = 0; i < n; i++) begin
         repeat (HALF) @(posedge clk);
         host_ck <= 1'b1;
         repeat (HALF) @(posedge clk);
         w[i] = data_in;
         host_ck <= 1'b0;
      end
      repeat (HALF) @(posedge clk);
   endtask
endmodule

/* spu_pkg.sv */
// Types shared by the serial port logic
package spu_pkg;
   typedef struct packed {
      logic       frame_err;
      logic       d9;
      logic [7:0] data;
   } spu_rx_entry_s;

   typedef enum logic [1:0] {
      SPU_ARX_IDLE  = 2'b00,
      SPU_ARX_START = 2'b01,
      SPU_ARX_DATA  = 2'b10
   } spu_arx_e;
endpackage

/* spu_serial_port.sv */
// Serial port control registers, shifters and sleep behaviour
`timescale 1ns/1ps
`include "spu_defs.svh"

module spu_serial_port
   import spu_pkg::*;
#(
   parameter logic [15:0] BAUD_DIV = 16'h0004
) (
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic [`SPU_ADDR_W-1:0] addr,
   input  wire logic [7:0]             wdata,
   input  wire logic                   wr,
   input  wire logic                   rd,
   output logic      [7:0]             rdata,
   input  wire logic                   cpu_sleep,
   input  wire logic                   data_in,
   output logic                        data_out,
   output logic                        data_oe_n,
   input  wire logic                   clk_pin_in,
   output logic                        clk_pin_out,
   output logic                        clk_pin_oe_n,
   output logic                        receive_flag,
   output logic                        transmit_flag
);

   if (BAUD_DIV == 16'h0000) begin : g_chk
      $error("BAUD_DIV must be at least one");
   end

   logic [7:0]    rxc;
   logic [7:0]    txc;
   logic [7:0]    bdc;
   logic          overrun;
   logic [7:0]    txbuf;
   logic          txbuf_full;
   logic [13:0]   tx_sr;
   logic [3:0]    tx_cnt;
   logic          tx_busy;
   logic          shift_pend;
   logic [15:0]   tx_tim;
   logic          hclk;
   logic [15:0]   hc_tim;
   logic          ck_prev;
   logic [8:0]    rsr;
   logic [3:0]    rx_cnt;
   logic [15:0]   rx_tim;
   spu_arx_e      arx;
   logic          d_prev;
   logic          d_s1;
   logic          d_s2;
   logic          c_s1;
   logic          c_s2;
   spu_rx_entry_s fifo_mem [2];
   logic          fifo_wp;
   logic          fifo_rp;
   logic [1:0]    fifo_cnt;
   spu_rx_entry_s push_ent;
   logic          push;
   logic [8:0]    next_word;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   function automatic logic [15:0] bit_period(input logic hs, input logic wide);
      logic [2:0] sh;
      sh = hs ? (wide ? `SPU_SHIFT_DIV4 : `SPU_SHIFT_DIV16)
              : (wide ? `SPU_SHIFT_DIV16 : `SPU_SHIFT_DIV64);
      return 16'(BAUD_DIV << sh);
   endfunction

   function automatic logic hit(input logic [`SPU_ADDR_W-1:0] a,
                                input logic [`SPU_ADDR_W-1:0] o);
      return a == o;
   endfunction

   // Mode decode
   wire port_en   = rxc[`SPU_RXC_PORT_EN];
   wire syncm     = txc[`SPU_TXC_SYNC];
   wire host      = txc[`SPU_TXC_CLK_SRC];
   wire client    = syncm & ~host;
   wire act       = port_en & (~cpu_sleep | client);
   wire sync_rx   = syncm & (rxc[`SPU_RXC_CONT] | (rxc[`SPU_RXC_ONCE] & host));
   wire sync_tx   = syncm & txc[`SPU_TXC_TX_EN] & ~sync_rx;
   wire arx_en    = ~syncm & rxc[`SPU_RXC_CONT];
   wire [3:0] nb_tx = txc[`SPU_TXC_NINE] ? `SPU_BITS_9 : `SPU_BITS_8;
   wire [3:0] nb_rx = rxc[`SPU_RXC_NINE] ? `SPU_BITS_9 : `SPU_BITS_8;
   wire [15:0] period = bit_period(txc[`SPU_TXC_FAST], bdc[`SPU_BDC_WIDE]);
   wire idle_lvl  = bdc[`SPU_BDC_POLARITY];
   wire ck_level  = host ? hclk : c_s2;
   wire lead      = syncm & (ck_prev == idle_lvl) & (ck_level != idle_lvl);
   wire trail     = syncm & (ck_prev != idle_lvl) & (ck_level == idle_lvl);
   wire hrun      = act & syncm & host & ((tx_busy & sync_tx) | (sync_rx & ~overrun));
   wire tx_load   = act & ~tx_busy & txbuf_full & txc[`SPU_TXC_TX_EN] & (~syncm | sync_tx);
   wire a_shift   = act & tx_busy & ~syncm & (tx_tim == 16'h0000);
   wire brk_done  = a_shift & (tx_cnt == 4'h1) & (tx_sr[12:0] == 13'h1fff) & txc[`SPU_TXC_BREAK];
   wire pop       = rd & hit(addr, `SPU_RXDATA_ADDR) & (fifo_cnt != 2'h0);
   wire ovr_set   = push & ~overrun & (fifo_cnt == `SPU_FIFO_FULL) & ~pop;
   wire push_ok   = push & ~overrun & ~ovr_set;
   wire once_done = push & host & syncm & ~rxc[`SPU_RXC_CONT];
   wire wr_rxc    = wr & hit(addr, `SPU_RXC_ADDR);
   spu_rx_entry_s head;
   assign head = (fifo_cnt != 2'h0) ? fifo_mem[fifo_rp] : '0;

   assign receive_flag  = port_en & (fifo_cnt != 2'h0);
   assign transmit_flag = port_en & txc[`SPU_TXC_TX_EN] & ~txbuf_full;

   // Pin synchronisers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         d_s1 <= 1'b1;
         d_s2 <= 1'b1;
         c_s1 <= 1'b0;
         c_s2 <= 1'b0;
      end else begin
         d_s1 <= data_in;
         d_s2 <= d_s1;
         c_s1 <= clk_pin_in;
         c_s2 <= c_s1;
      end
   end

   // Control registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxc <= `SPU_RXC_RESET;
         txc <= `SPU_TXC_RESET & `SPU_TXC_WMASK;
         bdc <= `SPU_BDC_RESET & `SPU_BDC_WMASK;
      end else begin
         if (wr_rxc) begin
            rxc <= wdata & `SPU_RXC_WMASK;
         end else if (once_done) begin
            rxc[`SPU_RXC_ONCE] <= 1'b0;
         end
         if (wr & hit(addr, `SPU_TXC_ADDR)) begin
            txc <= wdata & `SPU_TXC_WMASK;
         end else if (brk_done) begin
            txc[`SPU_TXC_BREAK] <= 1'b0;
         end
         if (wr & hit(addr, `SPU_BDC_ADDR)) begin
            bdc <= wdata & `SPU_BDC_WMASK;
         end
      end
   end

   // Transmit buffer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         txbuf      <= 8'h00;
         txbuf_full <= 1'b0;
      end else if (!port_en) begin
         txbuf_full <= 1'b0;
      end else if (tx_load) begin
         txbuf_full <= 1'b0;
      end else if (wr & hit(addr, `SPU_TXDATA_ADDR) & ~txbuf_full) begin
         txbuf      <= wdata;
         txbuf_full <= 1'b1;
      end
   end

   // Transmit shifter
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_sr      <= '1;
         tx_cnt     <= 4'h0;
         tx_busy    <= 1'b0;
         shift_pend <= 1'b0;
         tx_tim     <= 16'h0000;
      end else if (!port_en) begin
         tx_sr      <= '1;
         tx_cnt     <= 4'h0;
         tx_busy    <= 1'b0;
         shift_pend <= 1'b0;
         tx_tim     <= 16'h0000;
      end else if (tx_load) begin
         tx_busy    <= 1'b1;
         shift_pend <= 1'b0;
         tx_tim     <= 16'(period - 16'h0001);
         if (syncm) begin
            tx_sr  <= {5'h1f, txc[`SPU_TXC_NINTH], txbuf};
            tx_cnt <= nb_tx;
         end else if (txc[`SPU_TXC_BREAK]) begin
            tx_sr  <= {1'b1, 13'h0000};
            tx_cnt <= `SPU_BREAK_LEN;
         end else begin
            tx_sr  <= txc[`SPU_TXC_NINE] ? {4'hf, txc[`SPU_TXC_NINTH], txbuf, 1'b0}
                                         : {5'h1f, txbuf, 1'b0};
            tx_cnt <= 4'(nb_tx + `SPU_FRAME_EXTRA);
         end
      end else if (a_shift) begin
         tx_sr  <= {1'b1, tx_sr[13:1]};
         tx_cnt <= 4'(tx_cnt - 4'h1);
         tx_tim <= 16'(period - 16'h0001);
         if (tx_cnt == 4'h1) begin
            tx_busy <= 1'b0;
         end
      end else if (act & tx_busy & ~syncm) begin
         tx_tim <= 16'(tx_tim - 16'h0001);
      end else if (act & tx_busy & sync_tx & trail) begin
         shift_pend <= 1'b1;
         tx_cnt     <= 4'(tx_cnt - 4'h1);
         if (tx_cnt == 4'h1) begin
            // Emptied shifter idles at stop level for a later async frame
            tx_busy <= 1'b0;
            tx_sr   <= '1;
         end
      end else if (act & tx_busy & sync_tx & lead & shift_pend) begin
         tx_sr      <= {1'b1, tx_sr[13:1]};
         shift_pend <= 1'b0;
      end
   end

   // Host clock generator
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hclk    <= 1'b0;
         hc_tim  <= 16'h0000;
         ck_prev <= 1'b0;
      end else begin
         ck_prev <= act ? ck_level : ck_prev;
         if (!hrun) begin
            hclk   <= idle_lvl;
            hc_tim <= 16'(BAUD_DIV - 16'h0001);
         end else if (hc_tim == 16'h0000) begin
            hclk   <= ~hclk;
            hc_tim <= 16'(BAUD_DIV - 16'h0001);
         end else begin
            hc_tim <= 16'(hc_tim - 16'h0001);
         end
      end
   end

   // Receive word completion
   always_comb begin
      next_word = rsr;
      push      = 1'b0;
      push_ent  = '0;
      if (syncm) begin
         next_word[rx_cnt] = d_s2;
         if (act & sync_rx & trail & (rx_cnt == 4'(nb_rx - 4'h1))) begin
            push          = 1'b1;
            push_ent.d9   = rxc[`SPU_RXC_NINE] & next_word[8];
            push_ent.data = next_word[7:0];
         end
      end else if (act & (arx == SPU_ARX_DATA) & (rx_tim == 16'h0000)) begin
         if (rx_cnt != nb_rx) begin
            next_word[rx_cnt] = d_s2;
         end else begin
            push          = ~(rxc[`SPU_RXC_ADDR_DET] & rxc[`SPU_RXC_NINE] & ~rsr[8]);
            push_ent.frame_err = ~d_s2;
            push_ent.d9   = rxc[`SPU_RXC_NINE] & rsr[8];
            push_ent.data = rsr[7:0];
         end
      end
   end

   // Receive shifter
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rsr    <= 9'h000;
         rx_cnt <= 4'h0;
         rx_tim <= 16'h0000;
         arx    <= SPU_ARX_IDLE;
         d_prev <= 1'b1;
      end else if (!port_en) begin
         rx_cnt <= 4'h0;
         arx    <= SPU_ARX_IDLE;
         d_prev <= 1'b1;
      end else if (act) begin
         d_prev <= d_s2;
         if (syncm) begin
            arx <= SPU_ARX_IDLE;
            if (!sync_rx) begin
               rx_cnt <= 4'h0;
            end else if (trail) begin
               rsr    <= next_word;
               rx_cnt <= push ? 4'h0 : 4'(rx_cnt + 4'h1);
            end
         end else begin
            case (arx)
               SPU_ARX_IDLE: begin
                  if (arx_en & d_prev & ~d_s2) begin
                     arx    <= SPU_ARX_START;
                     rx_tim <= {1'b0, period[15:1]};
                  end
               end
               SPU_ARX_START: begin
                  if (rx_tim != 16'h0000) begin
                     rx_tim <= 16'(rx_tim - 16'h0001);
                  end else if (d_s2) begin
                     arx <= SPU_ARX_IDLE;
                  end else begin
                     arx    <= SPU_ARX_DATA;
                     rx_cnt <= 4'h0;
                     rx_tim <= 16'(period - 16'h0001);
                  end
               end
               SPU_ARX_DATA: begin
                  if (rx_tim != 16'h0000) begin
                     rx_tim <= 16'(rx_tim - 16'h0001);
                  end else if (rx_cnt == nb_rx) begin
                     arx <= SPU_ARX_IDLE;
                  end else begin
                     rsr    <= next_word;
                     rx_cnt <= 4'(rx_cnt + 4'h1);
                     rx_tim <= 16'(period - 16'h0001);
                  end
               end
               default: begin
                  arx <= SPU_ARX_IDLE;
               end
            endcase
         end
      end
   end

   // Two-entry receive buffer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fifo_wp  <= 1'b0;
         fifo_rp  <= 1'b0;
         fifo_cnt <= 2'h0;
      end else if (!port_en) begin
         fifo_wp  <= 1'b0;
         fifo_rp  <= 1'b0;
         fifo_cnt <= 2'h0;
      end else begin
         if (push_ok) begin
            fifo_mem[fifo_wp] <= push_ent;
            fifo_wp           <= ~fifo_wp;
         end
         if (pop) begin
            fifo_rp <= ~fifo_rp;
         end
         fifo_cnt <= 2'(fifo_cnt + {1'b0, push_ok} - {1'b0, pop});
      end
   end

   // Overrun status
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         overrun <= 1'b0;
      end else if (!port_en) begin
         overrun <= 1'b0;
      end else if (ovr_set) begin
         overrun <= 1'b1;
      end else if (wr_rxc & ~(wdata[`SPU_RXC_PORT_EN] & wdata[`SPU_RXC_CONT])) begin
         overrun <= 1'b0;
      end
   end

   // Register read port
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata <= 8'h00;
      end else if (!rd) begin
         rdata <= 8'h00;
      end else if (hit(addr, `SPU_RXC_ADDR)) begin
         rdata <= {rxc[7:3], head.frame_err, overrun, head.d9};
      end else if (hit(addr, `SPU_TXC_ADDR)) begin
         rdata <= {txc[7:2], ~tx_busy, txc[`SPU_TXC_NINTH]};
      end else if (hit(addr, `SPU_BDC_ADDR)) begin
         rdata <= {1'b0, arx == SPU_ARX_IDLE, bdc[5:0]};
      end else if (hit(addr, `SPU_RXDATA_ADDR)) begin
         rdata <= head.data;
      end else if (hit(addr, `SPU_TXDATA_ADDR)) begin
         rdata <= txbuf;
      end else begin
         rdata <= 8'h00;
      end
   end

   // Pin drivers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         data_out     <= 1'b1;
         data_oe_n    <= 1'b1;
         clk_pin_out  <= 1'b1;
         clk_pin_oe_n <= 1'b1;
      end else begin
         data_out     <= tx_sr[0];
         data_oe_n    <= ~(port_en & sync_tx);
         clk_pin_out  <= syncm ? hclk : (tx_sr[0] ^ idle_lvl);
         clk_pin_oe_n <= ~(port_en & (syncm ? host : txc[`SPU_TXC_TX_EN]));
      end
   end

   property p_sleep_hold;
      cpu_sleep && !client && port_en && !wr && !rd |=> $stable(tx_sr) && $stable(fifo_cnt);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("port moved in sleep");

   property p_client_edge;
      client && sync_tx && tx_busy && port_en && !trail && !wr |=> $stable(tx_cnt);
   endproperty
   a_client_edge: assert property (p_client_edge) else $error("client shift w/o edge");

   property p_rx_flag;
      push_ok |=> receive_flag;
   endproperty
   a_rx_flag: assert property (p_rx_flag) else $error("receive flag not set");

   property p_tx_refill;
      tx_load && !wr |=> tx_busy && !txbuf_full && (transmit_flag == $past(txc[`SPU_TXC_TX_EN]));
   endproperty
   a_tx_refill: assert property (p_tx_refill) else $error("refill did not free buffer");

   property p_tx_write;
      wr && hit(addr, `SPU_TXDATA_ADDR) && !txbuf_full && port_en |=> txbuf_full && !transmit_flag;
   endproperty
   a_tx_write: assert property (p_tx_write) else $error("write left flag set");

   property p_empty;
      rd && hit(addr, `SPU_TXC_ADDR) |=> rdata[`SPU_TXC_EMPTY] == !$past(tx_busy);
   endproperty
   a_empty: assert property (p_empty) else $error("shift empty status wrong");

   property p_rx_prio;
      sync_rx |=> data_oe_n;
   endproperty
   a_rx_prio: assert property (p_rx_prio) else $error("drove data while receiving");

   property p_port_off;
      !port_en |=> fifo_cnt == 2'h0 && !tx_busy && !overrun;
   endproperty
   a_port_off: assert property (p_port_off) else $error("port not held in reset");

   property p_once;
      once_done && !wr_rxc |=> !rxc[`SPU_RXC_ONCE];
   endproperty
   a_once: assert property (p_once) else $error("single receive not cleared");

   property p_overrun;
      ovr_set |=> overrun ##1 (overrun || !port_en || $past(wr_rxc));
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not held");

   c_sleep_rx: cover property (push_ok && client && cpu_sleep);
   c_sleep_tx: cover property (tx_load && client && cpu_sleep);
   c_overrun:  cover property (ovr_set);
   c_break:    cover property (brk_done);

endmodule
